// file: sg_dma_pkg.sv
// Package: constants, encodings and register map of the scatter-gather DMA engine
`default_nettype none
package sg_dma_pkg;
  // ************************************************************
  // Register map (byte addresses, word aligned)
  // ************************************************************
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] irq_status_off = 8'h04;
  localparam logic [7:0] irq_mask_off = 8'h08;
  localparam logic [7:0] busy_off = 8'h0c;
  localparam logic [7:0] chan_base = 8'h40;
  localparam logic [7:0] q_ptr_off = 8'h00;
  localparam logic [7:0] q_size_off = 8'h04;
  localparam logic [7:0] q_limit_off = 8'h08;
  localparam logic [7:0] q_next_off = 8'h0c;
  localparam int chan_shift = 6;
  localparam int queue_shift = 4;
  // ************************************************************
  // Queue element layout: 4 words
  // ************************************************************
  localparam int elem_words = 4;
  localparam int len_lsb = 0;
  localparam int len_w = 24;
  localparam int flag_loc_bit = 24;
  localparam int flag_eop_bit = 25;
  localparam int tag_lsb = 0;
  localparam int tag_w = 16;
  localparam logic [31:0] status_done = 32'h8000_0000;
  // Queue indices inside a channel
  localparam logic [1:0] q_src = 2'h0;
  localparam logic [1:0] q_dst = 2'h1;
  localparam logic [1:0] q_src_stat = 2'h2;
  localparam logic [1:0] q_dst_stat = 2'h3;
  // Control register fields
  localparam int ctrl_en_lsb = 0;
  localparam int ctrl_dir_lsb = 4;
  // Memory port select
  localparam logic port_host = 1'b0;
  localparam logic port_card = 1'b1;
endpackage
`default_nettype wire

// file: sg_dma_mover.sv
// Single-word mover: reads one word from host or card, writes to host or card
`default_nettype none
module sg_dma_mover (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic start,
  input wire logic src_port,
  input wire logic [31:0] src_addr,
  input wire logic dst_port,
  input wire logic [31:0] dst_addr,
  output logic done,
  output logic mem_rd,
  output logic mem_wr,
  output logic mem_port,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack
);
  typedef enum logic [1:0] {
    mv_idle = 2'b00,
    mv_read = 2'b01,
    mv_write = 2'b10
  } mv_state_e;

  typedef struct packed {
    mv_state_e st;
    logic [31:0] data;
    logic done;
  } mv_s;

  mv_s s_reg, s_next;

  // ************************************************************
  // Read then write; each leg waits for the port acknowledge
  // ************************************************************
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    unique case (s_reg.st)
      mv_idle: begin
        if (start) begin
          s_next.st = mv_read;
        end
      end
      mv_read: begin
        if (mem_ack) begin
          s_next.data = mem_rdata;
          s_next.st = mv_write;
        end
      end
      mv_write: begin
        if (mem_ack) begin
          s_next.done = 1'b1;
          s_next.st = mv_idle;
        end
      end
      default: s_next.st = mv_idle;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // Port select follows the leg in progress
  assign mem_rd = (s_reg.st == mv_read);
  assign mem_wr = (s_reg.st == mv_write);
  assign mem_port = (s_reg.st == mv_write) ? dst_port : src_port;
  assign mem_addr = (s_reg.st == mv_write) ? dst_addr : src_addr;
  assign mem_wdata = s_reg.data;
  assign done = s_reg.done;
endmodule // sg_dma_mover
`default_nettype wire

// file: sg_dma_engine.sv
// Scatter-gather DMA engine: four channels (channel 3 registers not addressable), host-resident queues, Avalon-MM registers
// Notes on behaviour
// - Host-to-card reads source, destination elements and source data over PCIe.
// - Host-to-card data goes out as AXI writes at destination element address.
// - Host-to-card completion writes both source and destination status queues.
// - Card-to-host first fetches destination then source elements from host.
// - Card-to-host reads source data over AXI at source element address.
// - Card-to-host writes data to host, only then updates both status queues.
// - Location flag clear means buffer lives in host memory, reached over PCIe.
// - Location flag set means buffer or FIFO lives on card AXI side.
// - Both elements' location flags pick source and target of each move.
// - Four channels, four lists each, all lists in host memory; channel 3 lists lie outside the 8-bit register address range.
// - Status entries written only on end-of-packet elements.
// - Destination status carries last destination element tag and packet length; code keeps only tag bits 7:0.
// - Consume elements up to software limit; wrap when limit equals size.
//
// Local design decisions: the Avalon-MM interface to the registers and the register addresses.
`default_nettype none
module sg_dma_engine #(
  parameter int num_chan = 4
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  output logic host_rd,
  output logic host_wr,
  output logic [31:0] host_addr,
  output logic [31:0] host_wdata,
  input wire logic [31:0] host_rdata,
  input wire logic host_ack,
  output logic card_rd,
  output logic card_wr,
  output logic [31:0] card_addr,
  output logic [31:0] card_wdata,
  input wire logic [31:0] card_rdata,
  input wire logic card_ack
);
  // Queue and status decode is laid out for exactly four channels
  if (num_chan != 4) begin : g_bad_chan
    $error("num_chan must be 4");
  end

  typedef enum logic [3:0] {
    st_pick = 4'b0000,
    st_fetch_a = 4'b0001,
    st_fetch_b = 4'b0010,
    st_move = 4'b0011,
    st_move_wait = 4'b0100,
    st_stat_a = 4'b0101,
    st_stat_b = 4'b0110,
    st_advance = 4'b0111
  } eng_state_e;

  typedef struct packed {
    eng_state_e st;
    logic [1:0] ch;
    logic [1:0] fq;
    logic [1:0] widx;
    logic [3:0] en;
    logic [3:0] dir;
    logic [3:0][3:0][31:0] qptr;
    logic [3:0][3:0][15:0] qsize;
    logic [3:0][3:0][15:0] qlimit;
    logic [3:0][3:0][15:0] qnext;
    logic [3:0][31:0] src_e;
    logic [3:0][31:0] dst_e;
    logic [23:0] remain;
    logic [23:0] pkt_len;
    logic [31:0] src_a;
    logic [31:0] dst_a;
    logic [3:0] status;
    logic [3:0] mask;
    logic rd_pend;
    logic [31:0] rdata;
    logic mv_start;
  } eng_s;

  eng_s s_reg, s_next;
  logic mv_done, mv_rd, mv_wr, mv_port, mv_port_ack;
  logic [31:0] mv_addr, mv_wdata, mv_rdata;

  // ************************************************************
  // Helpers
  // ************************************************************
  // Element address in host memory from queue base and index
  function automatic logic [31:0] elem_addr(input logic [31:0] base, input logic [15:0] idx,
                                            input logic [1:0] w);
    elem_addr = base + {12'h000, idx, 4'h0} + {28'h0000000, w, 2'b00};
  endfunction

  // Next index with wrap at queue size
  function automatic logic [15:0] bump(input logic [15:0] idx, input logic [15:0] size);
    bump = (idx + 16'h0001 >= size) ? 16'h0000 : idx + 16'h0001;
  endfunction

  // An element is available while next index differs from software limit, or from zero when limit equals size
  function automatic logic avail(input logic [15:0] nxt, input logic [15:0] lim,
                                 input logic [15:0] size);
    avail = (nxt != ((lim == size) ? 16'h0000 : lim));
  endfunction

  logic [1:0] ch;
  logic src_ready, dst_ready;
  assign ch = s_reg.ch;
  assign src_ready = avail(s_reg.qnext[ch][sg_dma_pkg::q_src],
                           s_reg.qlimit[ch][sg_dma_pkg::q_src],
                           s_reg.qsize[ch][sg_dma_pkg::q_src]);
  assign dst_ready = avail(s_reg.qnext[ch][sg_dma_pkg::q_dst],
                           s_reg.qlimit[ch][sg_dma_pkg::q_dst],
                           s_reg.qsize[ch][sg_dma_pkg::q_dst]);

  // ************************************************************
  // Engine and register file
  // ************************************************************
  logic [7:0] reg_off;
  logic [1:0] reg_ch, reg_q;
  logic chan_hit;
  logic [31:0] rd_mux;
  assign chan_hit = (avs_address >= sg_dma_pkg::chan_base);
  assign reg_ch = 2'((avs_address - sg_dma_pkg::chan_base) >> sg_dma_pkg::chan_shift);
  assign reg_q = 2'(avs_address >> sg_dma_pkg::queue_shift);
  assign reg_off = avs_address & 8'h0c;

  // Read decode; unmapped words read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (chan_hit) begin
      unique case (reg_off)
        sg_dma_pkg::q_ptr_off: rd_mux = s_reg.qptr[reg_ch][reg_q];
        sg_dma_pkg::q_size_off: rd_mux = {16'h0000, s_reg.qsize[reg_ch][reg_q]};
        sg_dma_pkg::q_limit_off: rd_mux = {16'h0000, s_reg.qlimit[reg_ch][reg_q]};
        default: rd_mux = {16'h0000, s_reg.qnext[reg_ch][reg_q]};
      endcase
    end else begin
      unique case (avs_address)
        sg_dma_pkg::ctrl_off: rd_mux = {24'h000000, s_reg.dir, s_reg.en};
        sg_dma_pkg::irq_status_off: rd_mux = {28'h0000000, s_reg.status};
        sg_dma_pkg::irq_mask_off: rd_mux = {28'h0000000, s_reg.mask};
        sg_dma_pkg::busy_off: rd_mux = {28'h0000000, 2'b00, s_reg.ch} |
                                       ((s_reg.st != st_pick) ? 32'h0000_0010 : 32'h0);
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    logic [3:0] ev;
    ev = 4'h0;
    s_next = s_reg;
    s_next.mv_start = 1'b0;
    // Reads answer one cycle after they are seen
    s_next.rd_pend = avs_read && !s_reg.rd_pend;
    s_next.rdata = rd_mux;
    if (avs_write) begin
      if (chan_hit) begin
        unique case (reg_off)
          sg_dma_pkg::q_ptr_off: s_next.qptr[reg_ch][reg_q] = avs_writedata;
          sg_dma_pkg::q_size_off: s_next.qsize[reg_ch][reg_q] = avs_writedata[15:0];
          sg_dma_pkg::q_limit_off: s_next.qlimit[reg_ch][reg_q] = avs_writedata[15:0];
          default: s_next.qnext[reg_ch][reg_q] = avs_writedata[15:0];
        endcase
      end else if (avs_address == sg_dma_pkg::ctrl_off) begin
        s_next.en = avs_writedata[sg_dma_pkg::ctrl_en_lsb +: 4];
        s_next.dir = avs_writedata[sg_dma_pkg::ctrl_dir_lsb +: 4];
      end else if (avs_address == sg_dma_pkg::irq_mask_off) begin
        s_next.mask = avs_writedata[3:0];
      end
    end
    unique case (s_reg.st)
      // Round robin: skip a channel without work so others proceed
      st_pick: begin
        if (s_reg.en[ch] && src_ready && dst_ready) begin
          s_next.st = st_fetch_a;
          s_next.widx = 2'b00;
          // Card-to-host fetches destination first, host-to-card source first
          s_next.fq = s_reg.dir[ch] ? sg_dma_pkg::q_dst : sg_dma_pkg::q_src;
        end else begin
          s_next.ch = ch + 2'b01;
        end
      end
      // Fetch the element words of both queues, first queue then second, over the host port
      st_fetch_a, st_fetch_b: begin
        if (host_ack) begin
          if (s_reg.fq == sg_dma_pkg::q_src) begin
            s_next.src_e[s_reg.widx] = host_rdata;
          end else begin
            s_next.dst_e[s_reg.widx] = host_rdata;
          end
          s_next.widx = s_reg.widx + 2'b01;
          if (s_reg.widx == 2'(sg_dma_pkg::elem_words - 1)) begin
            s_next.fq = (s_reg.fq == sg_dma_pkg::q_src) ? sg_dma_pkg::q_dst : sg_dma_pkg::q_src;
            s_next.st = (s_reg.st == st_fetch_a) ? st_fetch_b : st_move;
            if (s_reg.st == st_fetch_b) begin
              // Word 0 of both elements is already held; the last word is not an address
              s_next.src_a = s_reg.src_e[0];
              s_next.dst_a = s_reg.dst_e[0];
              s_next.remain = s_reg.src_e[1][sg_dma_pkg::len_lsb +: sg_dma_pkg::len_w];
            end
          end
        end
      end
      // Move one word per round of the mover
      st_move: begin
        if (s_reg.remain == 24'h000000) begin
          s_next.st = s_reg.src_e[1][sg_dma_pkg::flag_eop_bit] ? st_stat_a : st_advance;
          s_next.widx = 2'b00;
        end else begin
          s_next.mv_start = 1'b1;
          s_next.st = st_move_wait;
        end
      end
      st_move_wait: begin
        if (mv_done) begin
          s_next.src_a = s_reg.src_a + 32'h0000_0004;
          s_next.dst_a = s_reg.dst_a + 32'h0000_0004;
          s_next.remain = (s_reg.remain > 24'h000004) ? s_reg.remain - 24'h000004 : 24'h000000;
          s_next.pkt_len = s_reg.pkt_len + 24'h000004;
          s_next.st = st_move;
        end
      end
      // Status writes happen only after all data is written
      st_stat_a: begin
        if (host_ack) begin
          s_next.st = st_stat_b;
        end
      end
      st_stat_b: begin
        if (host_ack) begin
          s_next.pkt_len = 24'h000000;
          ev[ch] = 1'b1;
          s_next.st = st_advance;
        end
      end
      st_advance: begin
        s_next.qnext[ch][sg_dma_pkg::q_src] = bump(s_reg.qnext[ch][sg_dma_pkg::q_src],
                                                  s_reg.qsize[ch][sg_dma_pkg::q_src]);
        s_next.qnext[ch][sg_dma_pkg::q_dst] = bump(s_reg.qnext[ch][sg_dma_pkg::q_dst],
                                                  s_reg.qsize[ch][sg_dma_pkg::q_dst]);
        if (s_reg.src_e[1][sg_dma_pkg::flag_eop_bit]) begin
          s_next.qnext[ch][sg_dma_pkg::q_src_stat] = bump(
            s_reg.qnext[ch][sg_dma_pkg::q_src_stat], s_reg.qsize[ch][sg_dma_pkg::q_src_stat]);
          s_next.qnext[ch][sg_dma_pkg::q_dst_stat] = bump(
            s_reg.qnext[ch][sg_dma_pkg::q_dst_stat], s_reg.qsize[ch][sg_dma_pkg::q_dst_stat]);
        end
        s_next.ch = ch + 2'b01;
        s_next.st = st_pick;
      end
      default: s_next.st = st_pick;
    endcase
    // Sticky status: write one clears, a new event wins
    if (avs_write && !chan_hit && avs_address == sg_dma_pkg::irq_status_off) begin
      s_next.status = s_reg.status & ~avs_writedata[3:0];
    end
    s_next.status = s_next.status | ev;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // ************************************************************
  // Data mover and port steering
  // ************************************************************
  // Source and target chosen from each element's location flag
  logic src_loc, dst_loc;
  assign src_loc = s_reg.src_e[1][sg_dma_pkg::flag_loc_bit];
  assign dst_loc = s_reg.dst_e[1][sg_dma_pkg::flag_loc_bit];
  assign mv_rdata = (mv_port == sg_dma_pkg::port_card) ? card_rdata : host_rdata;
  assign mv_port_ack = (mv_port == sg_dma_pkg::port_card) ? card_ack : host_ack;

  sg_dma_mover u_mover (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .start(s_reg.mv_start),
    .src_port(src_loc),
    .src_addr(s_reg.src_a),
    .dst_port(dst_loc),
    .dst_addr(s_reg.dst_a),
    .done(mv_done),
    .mem_rd(mv_rd),
    .mem_wr(mv_wr),
    .mem_port(mv_port),
    .mem_addr(mv_addr),
    .mem_wdata(mv_wdata),
    .mem_rdata(mv_rdata),
    .mem_ack(mv_port_ack & ce)
  );

  // Host port serves element fetch, status writes and host-side data
  logic fetch_on, stat_on, mv_host, mv_card;
  logic [1:0] stat_q;
  assign fetch_on = (s_reg.st == st_fetch_a) || (s_reg.st == st_fetch_b);
  assign stat_on = (s_reg.st == st_stat_a) || (s_reg.st == st_stat_b);
  assign stat_q = (s_reg.st == st_stat_a) ? sg_dma_pkg::q_src_stat : sg_dma_pkg::q_dst_stat;
  assign mv_host = (mv_rd || mv_wr) && (mv_port == sg_dma_pkg::port_host);
  assign mv_card = (mv_rd || mv_wr) && (mv_port == sg_dma_pkg::port_card);

  always_comb begin
    host_rd = fetch_on || (mv_host && mv_rd);
    host_wr = stat_on || (mv_host && mv_wr);
    host_addr = mv_addr;
    host_wdata = mv_wdata;
    if (fetch_on) begin
      host_addr = elem_addr(s_reg.qptr[ch][s_reg.fq], s_reg.qnext[ch][s_reg.fq], s_reg.widx);
    end else if (stat_on) begin
      host_addr = elem_addr(s_reg.qptr[ch][stat_q], s_reg.qnext[ch][stat_q], 2'b00);
      // Source status: source tag; destination status: low 8 bits of last destination tag and packet length
      host_wdata = sg_dma_pkg::status_done |
                   {8'h00, (s_reg.st == st_stat_b) ? s_reg.pkt_len :
                    {8'h00, s_reg.src_e[2][sg_dma_pkg::tag_lsb +: sg_dma_pkg::tag_w]}};
      if (s_reg.st == st_stat_b) begin
        host_wdata = sg_dma_pkg::status_done | {8'h00, s_reg.pkt_len}
                     | {s_reg.dst_e[2][7:0], 24'h000000};
      end
    end
    card_rd = mv_card && mv_rd;
    card_wr = mv_card && mv_wr;
    card_addr = mv_addr;
    card_wdata = mv_wdata;
  end

  // ************************************************************
  // Bus answer and interrupt
  // ************************************************************
  assign avs_waitrequest = avs_read && !s_reg.rd_pend;
  assign avs_readdata = s_reg.rdata;
  assign irq = |(s_reg.status & s_reg.mask);
endmodule // sg_dma_engine
`default_nettype wire

// file: sg_dma_engine_assertions.sv
// Checker: port assertions for the DMA engine
`default_nettype none
module sg_dma_engine_chk (
  input wire logic clk,
  input wire logic srst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic irq,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [31:0] host_addr,
  input wire logic [31:0] host_rdata,
  input wire logic host_ack,
  input wire logic card_rd,
  input wire logic card_wr,
  input wire logic [31:0] card_addr,
  input wire logic [31:0] card_wdata,
  input wire logic [31:0] card_rdata,
  input wire logic card_ack,
  input wire logic [31:0] host_wdata
);
  // ************************************************************
  // Last words read on each port
  // ************************************************************
  logic [31:0] host_word_reg;
  logic [31:0] card_word_reg;
  logic card_pend_reg;
  // Pending flag keeps status writes off card data
  always_ff @(posedge clk) begin
    if (host_rd && host_ack) host_word_reg <= host_rdata;
    if (card_rd && card_ack) card_word_reg <= card_rdata;
    if (srst || (host_wr && host_ack)) card_pend_reg <= 1'b0;
    else if (card_rd && card_ack) card_pend_reg <= 1'b1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_read_first;
    avs_read && avs_waitrequest;
  endsequence
  sequence s_host_wait;
    host_rd && !host_ack;
  endsequence
  a_write_no_wait: assert property (avs_write |-> !avs_waitrequest)
    else $error("write waited");
  a_read_waits_first: assert property ($rose(avs_read) |-> avs_waitrequest)
    else $error("read no wait");
  a_read_one_wait: assert property (s_read_first |=> !avs_waitrequest)
    else $error("read wait too long");
  a_host_req_hold: assert property (s_host_wait |=> host_rd && $stable(host_addr))
    else $error("host read dropped");
  a_card_wr_hold: assert property (card_wr && !card_ack |=> card_wr && $stable(card_addr)
    && $stable(card_wdata)) else $error("card write dropped");
  a_host_dir_excl: assert property (!(host_rd && host_wr))
    else $error("host rd and wr");
  a_one_outstanding: assert property (!((host_rd || host_wr) && (card_rd || card_wr)))
    else $error("both ports busy");
  a_card_wdata_src: assert property (card_wr |-> card_wdata == host_word_reg)
    else $error("card data wrong");
  a_host_wdata_src: assert property (host_wr && card_pend_reg
    |-> host_wdata == card_word_reg) else $error("host data wrong");
  a_reset_quiet: assert property (disable iff (1'b0) srst |=> !host_rd && !host_wr && !card_rd
    && !card_wr && !irq) else $error("busy after reset");
endmodule // sg_dma_engine_chk
bind sg_dma_engine sg_dma_engine_chk i_chk (
  .clk(clk), .srst(srst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .irq(irq), .host_rd(host_rd), .host_wr(host_wr),
  .host_addr(host_addr), .host_rdata(host_rdata), .host_ack(host_ack), .card_rd(card_rd),
  .card_wr(card_wr), .card_addr(card_addr), .card_wdata(card_wdata),
  .card_rdata(card_rdata), .card_ack(card_ack), .host_wdata(host_wdata)
);
`default_nettype wire

// file: sg_mem_model.sv
// Partner model: word-wide memory port for host or card
`default_nettype none
module sg_mem_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic slow,
  input wire logic rd,
  input wire logic wr,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  output logic [31:0] rdata,
  output logic ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [0:1023];
  logic [31:0] wr_log [$];
  logic [2:0] wait_cnt;
  initial begin
    ack = 1'b0;
    rdata = 32'h5a5a_a5a5;
    wait_cnt = 3'h0;
  end
  // Ack after one or four cycles; rdata scrambles off answer
  always @(posedge clk) begin
    if (srst || ack) begin
      ack <= 1'b0;
      wait_cnt <= 3'h0;
      rdata <= ~rdata;
    end else if ((rd || wr) && wait_cnt >= (slow ? 3'h3 : 3'h0)) begin
      ack <= 1'b1;
      if (wr) mem[addr[11:2]] <= wdata;
      if (wr) wr_log.push_back(addr);
      rdata <= rd ? mem[addr[11:2]] : ~rdata;
    end else begin
      wait_cnt <= wait_cnt + ((rd || wr) ? 3'h1 : 3'h0);
      rdata <= ~rdata;
    end
  end
endmodule // sg_mem_model
`default_nettype wire

// file: tb_top.sv
// Testbench: both transfer directions, status and interrupt
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, srst, ce, slow, avs_read, avs_write, avs_waitrequest, irq;
  logic host_rd, host_wr, host_ack, card_rd, card_wr, card_ack;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, host_addr, host_wdata, host_rdata;
  logic [31:0] card_addr, card_wdata, card_rdata, lfsr_reg, rd_word;
  int miscompares, total_checks;
  int cycles = 0;
  sg_dma_engine #(.num_chan(4)) i_dut (.clk(clk), .srst(srst), .ce(ce),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .host_rd(host_rd), .host_wr(host_wr),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .host_ack(host_ack), .card_rd(card_rd), .card_wr(card_wr), .card_addr(card_addr),
    .card_wdata(card_wdata), .card_rdata(card_rdata), .card_ack(card_ack));
  sg_mem_model i_host (.clk(clk), .srst(srst), .slow(slow), .rd(host_rd), .wr(host_wr),
    .addr(host_addr), .wdata(host_wdata), .rdata(host_rdata), .ack(host_ack));
  sg_mem_model i_card (.clk(clk), .srst(srst), .slow(slow), .rd(card_rd), .wr(card_wr),
    .addr(card_addr), .wdata(card_wdata), .rdata(card_rdata), .ack(card_ack));
  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] qreg(input int ch, input int q, input logic [7:0] off);
    return sg_dma_pkg::chan_base + 8'(ch << sg_dma_pkg::chan_shift)
      + 8'(q << sg_dma_pkg::queue_shift) + off;
  endfunction
  // Queue base in host memory
  function automatic logic [31:0] qmem(input int ch, input int q);
    return 32'h100 + 32'(q) * 32'h100 + 32'(ch) * 32'h40;
  endfunction
  function automatic logic [31:0] dst_stat(input logic [31:0] tag, input int len);
    return sg_dma_pkg::status_done | {tag[7:0], 24'h0} | 32'(len);
  endfunction
  task automatic rnd(output logic [31:0] v);
    lfsr_reg = lfsr_step(lfsr_reg);
    v = lfsr_reg;
  endtask
  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Entry waits one edge
  task automatic avs_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask
  task automatic avs_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask
  task automatic check_irq(input logic exp);
    @(posedge clk);
    check32({31'h0, irq}, {31'h0, exp});
  endtask
  // ************************************************************
  // One packet on one channel, then status, index and interrupt checks
  // ************************************************************
  task automatic xfer(input int ch, input logic dir, input int nw);
    logic [31:0] v, stag, dtag, sbuf, dbuf;
    logic [31:0] exp_data [4];
    int i, sq, dq, db;
    sbuf = 32'h800 + 32'(ch) * 32'h40;
    dbuf = 32'hc00 + 32'(ch) * 32'h40;
    sq = qmem(ch, 0) >> 2;
    dq = qmem(ch, 1) >> 2;
    db = dbuf >> 2;
    rnd(stag);
    rnd(dtag);
    i_host.mem[sq] = sbuf;
    i_host.mem[sq + 1] = 32'(nw * 4) | {6'h0, 1'b1, dir, 24'h0};
    i_host.mem[sq + 2] = {16'h0, stag[15:0]};
    i_host.mem[dq] = dbuf;
    i_host.mem[dq + 1] = 32'(nw * 4) | {6'h0, 1'b1, ~dir, 24'h0};
    i_host.mem[dq + 2] = {16'h0, dtag[15:0]};
    for (i = 0; i < nw; i++) begin
      rnd(v);
      exp_data[i] = v;
      if (dir) i_card.mem[(sbuf >> 2) + i] = v;
      else i_host.mem[(sbuf >> 2) + i] = v;
    end
    for (i = 0; i < 4; i++) begin
      avs_wr(qreg(ch, i, sg_dma_pkg::q_ptr_off), qmem(ch, i));
      avs_wr(qreg(ch, i, sg_dma_pkg::q_size_off), 32'h4);
      avs_wr(qreg(ch, i, sg_dma_pkg::q_limit_off), 32'h1);
      avs_wr(qreg(ch, i, sg_dma_pkg::q_next_off), 32'h0);
    end
    i_host.wr_log.delete();
    i_card.wr_log.delete();
    avs_wr(sg_dma_pkg::ctrl_off, 32'(1 << ch) | 32'(dir) << (4 + ch));
    for (i = 0; i < 300; i++) begin
      avs_rd(sg_dma_pkg::irq_status_off, v);
      if (v[ch] === 1'b1) break;
    end
    for (i = 0; i < nw; i++) begin
      check32(dir ? i_host.mem[db + i] : i_card.mem[db + i], exp_data[i]);
    end
    check32(32'(i_host.wr_log.size()), 32'(dir ? nw + 2 : 2));
    check32(32'(i_card.wr_log.size()), 32'(dir ? 0 : nw));
    for (i = 0; i < nw && dir; i++) check32(i_host.wr_log[i], dbuf + 32'(i * 4));
    check32(i_host.wr_log[dir ? nw : 0], qmem(ch, 2));
    check32(i_host.wr_log[dir ? nw + 1 : 1], qmem(ch, 3));
    check32(i_host.mem[qmem(ch, 2) >> 2], sg_dma_pkg::status_done | {16'h0, stag[15:0]});
    check32(i_host.mem[qmem(ch, 3) >> 2], dst_stat(dtag, nw * 4));
    avs_rd(qreg(ch, 0, sg_dma_pkg::q_next_off), v);
    check32(v, 32'h1);
    // Interrupt: masked, unmasked, cleared
    check_irq(1'b0);
    avs_wr(sg_dma_pkg::irq_mask_off, 32'(1 << ch));
    check_irq(1'b1);
    avs_wr(sg_dma_pkg::irq_status_off, 32'(1 << ch));
    check_irq(1'b0);
    avs_rd(sg_dma_pkg::irq_status_off, v);
    check32(v, 32'h0);
    avs_wr(sg_dma_pkg::irq_mask_off, 32'h0);
  endtask
  task automatic complete_run;
    $display("miscompares=%0d total_checks=%0d", miscompares, total_checks);
    if (miscompares == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ************************************************************
  // Clock, timeout and main sequence
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Hang guard far above run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      complete_run;
    end
  end
  initial begin
    srst = 1'b1;
    ce = 1'b1;
    slow = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    lfsr_reg = 32'haa7c8e3a;
    miscompares = 0;
    total_checks = 0;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    avs_rd(sg_dma_pkg::ctrl_off, rd_word);
    check32(rd_word, 32'h0);
    avs_rd(sg_dma_pkg::irq_mask_off, rd_word);
    check32(rd_word, 32'h0);
    avs_wr(8'h20, 32'hffff_ffff);
    avs_rd(8'h20, rd_word);
    check32(rd_word, 32'h0);
    check_irq(1'b0);
    xfer(0, 1'b0, 2);
    slow <= 1'b1;
    xfer(1, 1'b1, 3);
    slow <= 1'b0;
    xfer(2, 1'b0, 4);
    complete_run;
  end
endmodule // tb_top
`default_nettype wire
